/* logic/cpu_state_sequencer_defs.vh */
/*
  Constants for the processor state sequencer: state codes, cycle types,
  bus control bit positions and reset values.
  Assumes inclusion by bare name from the sequencer design files.
*/
`ifndef CPU_STATE_SEQUENCER_DEFS_VH
`define CPU_STATE_SEQUENCER_DEFS_VH

// ------------------------------------------------------------------
// State codes (five-bit ring, one bit per state)
// ------------------------------------------------------------------
`define ST_T1        5'h01
`define ST_T2        5'h02
`define ST_T3        5'h04
`define ST_T4        5'h08
`define ST_T5        5'h10

// ------------------------------------------------------------------
// Cycle type codes driven on data bits seven and six during T2
// ------------------------------------------------------------------
`define CYC_FETCH    2'h0
`define CYC_READ     2'h2
`define CYC_IO       2'h1
`define CYC_WRITE    2'h3
`define CYC_POS_LO   6
`define CYC_POS_HI   7

// ------------------------------------------------------------------
// Flag positions on the bus during an output cycle T4
// ------------------------------------------------------------------
`define FLAG_POS_S   0
`define FLAG_POS_Z   1
`define FLAG_POS_P   2
`define FLAG_POS_C   3

// ------------------------------------------------------------------
// Reset values and widths
// ------------------------------------------------------------------
`define PC_RESET     14'h0000
`define RST_PC_LO    3
`define RST_PC_HI    5
`define PHASE_PER_ST 2

`endif

/* logic/state_shift_reg.v */
/*
  Five-bit feedback shift register that holds the current processor state.
  Assumes the caller supplies a one-cycle advance enable and the feedback
  selection derived from the instruction being executed.
*/
`timescale 1ns/1ps
`include "cpu_state_sequencer_defs.vh"

module state_shift_reg (
    clk_sys,
    rst,
    advance,
    hold_t3,
    skip_exec,
    skip_t3,
    state
);
    input  wire       clk_sys;
    input  wire       rst;
    input  wire       advance;
    input  wire       hold_t3;
    input  wire       skip_exec;
    input  wire       skip_t3;
    output reg  [4:0] state;

    // ------------------------------------------------------------------
    // Shift with selectable feedback
    // ------------------------------------------------------------------
    // Feedback taps: T3 recirculates, T3/T4 may return to T1, else shift
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= `ST_T1;
        end else if (advance) begin
            if (state[2] && hold_t3)
                state <= `ST_T3;
            else if (state[2] && skip_exec)
                state <= `ST_T1;
            else if (state[3] && skip_t3)
                state <= `ST_T1;
            else
                state <= {state[3:0], state[4]};
        end
    end
endmodule // state_shift_reg

/* logic/cpu_state_sequencer.v */
/*
  State sequencer of an 8-bit processor: walks T1..T5 per memory cycle,
  drives the multiplexed bus, handles wait, halt, skip and restart.
  Assumes phase inputs phi1/phi2 are synchronous, non-overlapping enables
  sampled on clk_sys, and that memory asserts ready to end T3 waits.
*/
// Function
// - Five states plus acknowledge and stopped
// - T1 drives low address, increments counter
// - Acknowledge T1 suppresses increment, signals ack
// - T2 drives high address and cycle bits
// - High part increments only on T1 carry
// - Wait in T3 until ready
// - T3 fetches, reads or writes byte
// - Halt stops until interrupt
// - T4/T5 execute, bus shows internal data
// - Unneeded T4/T5 skipped to T1
// - Phase one precharges, phase two transfers
// - Sync toggles on every phase two
// - State counter is feedback shift register
// - Wait and stop cycle in T3
// - State totals per instruction class
// - ALU register: T4 source, T5 operate
// - Increment idles T4, adds in T5
// - Decrement idles T4, subtracts in T5
// - Rotates idle T4, rotate in T5
// - Restart loads temps, then counter halves
// - Restart vector from instruction bits 3-5
// - Failed condition skips T4 and T5
// - First cycle of instruction is fetch
`timescale 1ns/1ps
`include "cpu_state_sequencer_defs.vh"

module cpu_state_sequencer (
    clk_sys,
    rst,
    phi1,
    phi2,
    ready,
    intr_req,
    data_in,
    reg_src,
    reg_l,
    reg_h,
    reg_acc,
    flag_s,
    flag_z,
    flag_p,
    flag_c,
    cond_true,
    stack_top,
    data_out,
    data_oe_n,
    sync,
    state_out,
    stopped,
    waiting,
    int_ack,
    refresh,
    precharge,
    transfer,
    instruction_holding_reg,
    temp_a,
    temp_b,
    pc,
    push_stack,
    pop_stack,
    alu_op_go,
    inc_op_go,
    dec_op_go,
    rot_op_go,
    load_dest
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire        phi1;
    input  wire        phi2;
    input  wire        ready;
    input  wire        intr_req;
    input  wire [7:0]  data_in;
    input  wire [7:0]  reg_src;
    input  wire [7:0]  reg_l;
    input  wire [7:0]  reg_h;
    input  wire [7:0]  reg_acc;
    input  wire        flag_s;
    input  wire        flag_z;
    input  wire        flag_p;
    input  wire        flag_c;
    input  wire        cond_true;
    input  wire [13:0] stack_top;
    output reg  [7:0]  data_out;
    output wire        data_oe_n;
    output reg         sync;
    output wire [4:0]  state_out;
    output reg         stopped;
    output wire        waiting;
    output reg         int_ack;
    output wire        refresh;
    output wire        precharge;
    output wire        transfer;
    output reg  [7:0]  instruction_holding_reg;
    output reg  [7:0]  temp_a;
    output reg  [7:0]  temp_b;
    output reg  [13:0] pc;
    output reg         push_stack;
    output reg         pop_stack;
    output reg         alu_op_go;
    output reg         inc_op_go;
    output reg         dec_op_go;
    output reg         rot_op_go;
    output reg         load_dest;

    // ------------------------------------------------------------------
    // Internal state
    // ------------------------------------------------------------------
    wire [4:0] state;
    reg  [1:0] cyc_reg;        // Type of the current memory cycle
    reg  [1:0] cyc_idx_reg;    // Memory cycle number within instruction
    reg        carry_reg;      // Carry from T1 low-byte increment
    reg        ack_cycle_reg;  // Current T1 is an interrupt acknowledge
    reg        drive_reg;
    reg        hold_t3;
    reg        skip_exec;
    reg        skip_t3;
    reg  [1:0] cyc_next;
    reg  [1:0] ncyc;           // Cycles the instruction needs
    reg  [1:0] cyc2_type;

    wire [7:0] ir = instruction_holding_reg;
    wire       adv = phi2 & sync;        // End of second period
    wire       is_t1 = state[0];
    wire       is_t2 = state[1];
    wire       is_t3 = state[2];
    wire       is_t4 = state[3];
    wire       is_t5 = state[4];

    // ------------------------------------------------------------------
    // Instruction class decode
    // ------------------------------------------------------------------
    wire d_halt  = (ir[7:1] == 7'h00) || (ir == 8'hff);
    wire d_mov   = (ir[7:6] == 2'h3) && (ir[2:0] != 3'h7)
                   && (ir[5:3] != 3'h7);
    wire d_ldm   = (ir[7:6] == 2'h3) && (ir[2:0] == 3'h7) && !d_halt;
    wire d_stm   = (ir[7:6] == 2'h3) && (ir[5:3] == 3'h7)
                   && (ir[2:0] != 3'h7);
    wire d_ldi   = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h6)
                   && (ir[5:3] != 3'h7);
    wire d_sti   = (ir[7:6] == 2'h0) && (ir[5:0] == 6'h3e);
    wire d_inc   = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h0) && !d_halt;
    wire d_dec   = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h1) && !d_halt;
    wire d_alur  = (ir[7:6] == 2'h2) && (ir[2:0] != 3'h7);
    wire d_alum  = (ir[7:6] == 2'h2) && (ir[2:0] == 3'h7);
    wire d_alui  = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h4);
    wire d_rot   = (ir[7:5] == 3'h0) && (ir[2:0] == 3'h2);
    wire d_jump  = (ir[7:6] == 2'h1) && (ir[2:0] == 3'h4 || ir[2:0] == 3'h0);
    wire d_call  = (ir[7:6] == 2'h1) && (ir[2:0] == 3'h6 || ir[2:0] == 3'h2);
    wire d_ret   = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h7 || ir[2:0] == 3'h3);
    wire d_cond  = (ir[1:0] == 2'h0 || ir[1:0] == 2'h2 || ir[1:0] == 2'h3)
                   && (d_jump || d_call || d_ret);
    wire d_rst   = (ir[7:6] == 2'h0) && (ir[2:0] == 3'h5);
    wire d_inp   = (ir[7:6] == 2'h1) && (ir[5:4] == 2'h0) && ir[0];
    wire d_out   = (ir[7:6] == 2'h1) && (ir[5:4] != 2'h0) && ir[0];
    wire cfail   = d_cond && !cond_true;
    // A fetched halt freezes the counter in T3 at the latching edge itself;
    // letting it pass to T1 would bump the counter once more
    wire halt_hold = (cyc_idx_reg == 2'h0) && !stopped
                     && ((data_in[7:1] == 7'h00) || (data_in == 8'hff));

    // ------------------------------------------------------------------
    // Cycle count and type of the following memory cycle per class
    // ------------------------------------------------------------------
    // Totals: one-cycle 5/3, two-cycle 8/6, three-cycle 11/9
    always @* begin
        ncyc = 2'h1;
        cyc2_type = `CYC_READ;
        if (d_ldm || d_ldi || d_alum || d_alui || d_stm || d_sti)
            ncyc = 2'h2;
        if (d_stm)
            cyc2_type = `CYC_WRITE;
        if (d_inp || d_out) begin
            ncyc = 2'h2;
            cyc2_type = `CYC_IO;
        end
        if (d_sti || d_jump || d_call)
            ncyc = 2'h3;
    end

    // Sequencing of T3 and T4 exits for the instruction in hand
    always @* begin
        hold_t3   = (!ready && !stopped) || (stopped && !intr_req);
        skip_exec = 1'b0;
        skip_t3   = 1'b0;
        if (cyc_idx_reg == 2'h0) begin
            // First cycle: decode from bus on T3, so look at data_in
            skip_exec = (data_in[7:1] == 7'h00) || (data_in == 8'hff)
                        || ir_needs_more(data_in);
        end else if (cyc_idx_reg != ncyc - 2'h1) begin
            skip_exec = 1'b1;
        end else if (cfail) begin
            skip_exec = 1'b1;
        end else begin
            skip_exec = d_stm || d_sti || d_out;
            skip_t3   = d_out;
        end
        if (cyc_idx_reg == 2'h0 && d_ret_fail(data_in, cond_true))
            skip_exec = 1'b1;
    end

    // Early decode: instructions whose first cycle hands straight to next
    function ir_needs_more;
        input [7:0] op;
        begin
            ir_needs_more = (op[7:6] == 2'h3 && op[2:0] == 3'h7)
                || (op[7:6] == 2'h0 && (op[2:0] == 3'h6 || op[2:0] == 3'h4))
                || (op[7:6] == 2'h2 && op[2:0] == 3'h7)
                || (op[7:6] == 2'h1 && (op[2:0] == 3'h4 || op[2:0] == 3'h0
                    || op[2:0] == 3'h6 || op[2:0] == 3'h2 || op[0]));
        end
    endfunction

    // Conditional return whose test fails ends after T3
    function d_ret_fail;
        input [7:0] op;
        input       cv;
        begin
            d_ret_fail = (op[7:6] == 2'h0) && (op[2:0] == 3'h3)
                         && !cv;
        end
    endfunction

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    state_shift_reg u_state (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .advance   (adv),
        .hold_t3   (hold_t3 | halt_hold),
        .skip_exec (skip_exec),
        .skip_t3   (skip_t3),
        .state     (state)
    );

    assign state_out = state;
    assign waiting   = is_t3 & !ready & !stopped;
    assign refresh   = is_t3;
    assign precharge = phi1;
    assign transfer  = phi2;
    assign data_oe_n = !drive_reg;

    // ------------------------------------------------------------------
    // Sync divider: marks which of the two periods is current
    // ------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            sync <= 1'b0;
        else if (phi2)
            sync <= !sync;
    end

    // Next memory cycle number when leaving the current one
    always @* begin
        cyc_next = cyc_idx_reg + 2'h1;
        if (cyc_idx_reg != 2'h0 && cyc_idx_reg == ncyc - 2'h1)
            cyc_next = 2'h0;
        if (cyc_idx_reg == 2'h0 && !ir_needs_more(data_in))
            cyc_next = 2'h0;
        if (cfail || (cyc_idx_reg == 2'h0 && d_ret_fail(data_in, cond_true)))
            cyc_next = 2'h0;
    end

    // ------------------------------------------------------------------
    // Datapath actions, bus drive and program counter
    // ------------------------------------------------------------------
    // Counter changes at completed state boundaries; bus is set at the first phase one of each state
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_out      <= 8'h00;
            drive_reg     <= 1'b0;
            pc            <= `PC_RESET;
            carry_reg     <= 1'b0;
            cyc_reg       <= `CYC_FETCH;
            cyc_idx_reg   <= 2'h0;
            ack_cycle_reg <= 1'b0;
            int_ack       <= 1'b0;
            stopped       <= 1'b0;
            instruction_holding_reg <= 8'h00;
            temp_a        <= 8'h00;
            temp_b        <= 8'h00;
            push_stack    <= 1'b0;
            pop_stack     <= 1'b0;
            alu_op_go     <= 1'b0;
            inc_op_go     <= 1'b0;
            dec_op_go     <= 1'b0;
            rot_op_go     <= 1'b0;
            load_dest     <= 1'b0;
        end else begin
            push_stack <= 1'b0;
            pop_stack  <= 1'b0;
            alu_op_go  <= 1'b0;
            inc_op_go  <= 1'b0;
            dec_op_go  <= 1'b0;
            rot_op_go  <= 1'b0;
            load_dest  <= 1'b0;
            if (phi1 && !sync) begin
                // Present the bus for the state just entered
                drive_reg <= 1'b1;
                int_ack   <= is_t1 & ack_cycle_reg;
                if (is_t1) begin
                    data_out <= (cyc_idx_reg == 2'h0) ? pc[7:0]
                              : (d_jump || d_call) ? pc[7:0]
                              : reg_l;
                end else if (is_t2) begin
                    data_out <= {cyc_reg,
                        ((cyc_idx_reg == 2'h0 || d_jump || d_call)
                          ? pc[13:8] : reg_h[5:0])};
                end else if (is_t3) begin
                    drive_reg <= (cyc_reg == `CYC_WRITE);
                    data_out  <= temp_b;
                end else if (is_t4) begin
                    data_out <= (cyc_reg == `CYC_IO) ?
                        {4'h0, flag_c, flag_p, flag_z, flag_s}
                        : reg_src;
                end else begin
                    data_out <= temp_b;
                end
            end
            if (adv) begin
                if (is_t1 && !ack_cycle_reg &&
                    (cyc_idx_reg == 2'h0 || d_jump || d_call)) begin
                    {carry_reg, pc[7:0]} <= {1'b0, pc[7:0]} + 9'h001;
                end
                if (is_t2 && carry_reg) begin
                    pc[13:8]  <= pc[13:8] + 6'h01;
                    carry_reg <= 1'b0;
                end
                if (is_t3 && stopped && intr_req) begin
                    stopped       <= 1'b0;
                    ack_cycle_reg <= 1'b1;
                end else if (is_t3 && !hold_t3) begin
                    cyc_idx_reg <= cyc_next;
                    if (cyc_next == 2'h0) begin
                        cyc_reg <= `CYC_FETCH;
                    end else begin
                        cyc_reg <= cyc2_type;
                    end
                    if (cyc_idx_reg == 2'h0) begin
                        instruction_holding_reg <= data_in;
                        temp_b <= data_in;
                        ack_cycle_reg <= 1'b0;
                        if ((data_in[7:1] == 7'h00) || (data_in == 8'hff))
                            stopped <= 1'b1;
                        if (data_in[7:6] == 2'h0 &&
                            data_in[2:0] == 3'h5) begin
                            push_stack <= 1'b1;
                            temp_a     <= 8'h00;
                            temp_b     <= {2'h0, data_in[5:3],
                                           3'h0};
                        end
                        if (ir_needs_more(data_in) &&
                            data_in[7:6] != 2'h1)
                            cyc_reg <= (data_in[7:6] == 2'h3 &&
                                data_in[5:3] == 3'h7) ? `CYC_WRITE
                                : `CYC_READ;
                        if (data_in[7:6] == 2'h1 && data_in[0])
                            cyc_reg <= `CYC_IO;
                        if (data_in[7:6] == 2'h1 && !data_in[0])
                            cyc_reg <= `CYC_READ;
                    end else if (cyc_idx_reg == 2'h1 &&
                                 cyc_next != 2'h0) begin
                        temp_b <= data_in;                     // Low address
                    end else begin
                        temp_a <= data_in;
                        if (!d_stm && !d_out)
                            temp_b <= (cyc_idx_reg == 2'h2) ? temp_b
                                      : data_in;
                    end
                    if (cyc_idx_reg == 2'h0 &&
                        d_ret_fail(data_in, cond_true))
                        cyc_reg <= `CYC_FETCH;
                end
                if (is_t4) begin
                    if (d_alur || d_mov || d_stm)
                        temp_b <= reg_src;
                    if (d_rst)
                        pc[13:8] <= temp_a[5:0];
                    if (d_ret && !cfail)
                        pc <= stack_top;
                    if (d_ret && !cfail)
                        pop_stack <= 1'b1;
                    if (d_call && !cfail)
                        push_stack <= 1'b1;
                    if ((d_jump || d_call) && !cfail)
                        pc[13:8] <= temp_a[5:0];
                    if (d_inp)
                        temp_b <= data_in;
                end
                if (is_t5) begin
                    alu_op_go <= d_alur || d_alum || d_alui;
                    inc_op_go <= d_inc;
                    dec_op_go <= d_dec;
                    rot_op_go <= d_rot;
                    load_dest <= d_mov || d_ldm || d_ldi || d_inp;
                    if (d_rst || ((d_jump || d_call) && !cfail))
                        pc[7:0] <= temp_b;
                end
                if (is_t5 && !d_inc && !d_rot && intr_req)
                    ack_cycle_reg <= 1'b1;
            end
        end
    end
endmodule // cpu_state_sequencer

/* test/cpu_state_sequencer_chk.sv */
/* Port checker for the state sequencer.
   Assumes one clock domain and binding into cpu_state_sequencer. */
`timescale 1ns/1ps
`include "cpu_state_sequencer_defs.vh"
module cpu_state_sequencer_chk (
    input wire        clk_sys,
    input wire        rst,
    input wire        phi1,
    input wire        phi2,
    input wire        ready,
    input wire        intr_req,
    input wire        sync,
    input wire [4:0]  state_out,
    input wire        stopped,
    input wire        int_ack,
    input wire        refresh,
    input wire        precharge,
    input wire        transfer,
    input wire [13:0] pc
);
    // ----------------
    // Timing relations
    // ----------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_sync_toggle: assert property (
        phi2 |=> sync != $past(sync)) else $error("sync stuck");
    // A change needs a state boundary one or two edges before
    a_whole_state: assert property (
        $changed(state_out) |-> $past(phi2 && sync) ||
        $past(phi2 && sync, 2)) else $error("mid-state advance");
    a_state_onehot: assert property (
        $onehot(state_out)) else $error("state not one-hot");
    a_wait_ready: assert property (
        !ready [*2] ##0 (state_out == `ST_T3 && !stopped)
        |=> state_out == `ST_T3) else $error("left T3 without ready");
    a_halt_holds: assert property (
        stopped && !intr_req |=> stopped && state_out == `ST_T3)
        else $error("halt released early");
    a_refresh_t3: assert property (
        refresh == (state_out == `ST_T3)) else $error("refresh off T3");
    a_phase_map: assert property (
        precharge == phi1 && transfer == phi2) else $error("phase map");
    a_ack_hold_pc: assert property (
        int_ack |-> $stable(pc)) else $error("pc moved during ack");
    cover property (stopped);
    cover property (int_ack);
    cover property (state_out == `ST_T5 && phi2);
endmodule // cpu_state_sequencer_chk

bind cpu_state_sequencer cpu_state_sequencer_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .phi1(phi1), .phi2(phi2),
    .ready(ready), .intr_req(intr_req), .sync(sync),
    .state_out(state_out), .stopped(stopped), .int_ack(int_ack),
    .refresh(refresh), .precharge(precharge), .transfer(transfer),
    .pc(pc));

/* test/mem_model.sv */
/* Memory and clock-source model on the far side of the bus.
   Assumes the bench seeds $urandom and fills mem during reset. */
`timescale 1ns/1ps
`include "cpu_state_sequencer_defs.vh"
module mem_model (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [4:0] state_out,
    input  wire [7:0] data_out,
    input  wire       data_oe_n,
    output reg        phi1,
    output reg        phi2,
    output reg        ready,
    output reg  [7:0] data_in
);
    reg [7:0] mem [0:255];
    reg [7:0] addr;
    // ------------------
    // Phases and answers
    // ------------------
    // Phases alternate one cycle each, never together
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phi1    <= 1'b0;
            phi2    <= 1'b0;
            ready   <= 1'b0;
            data_in <= 8'h00;
        end else begin
            phi1  <= ~phi1;
            phi2  <= phi1;
            ready <= ($urandom % 4) != 0; // Random stalls in T3
            if (state_out == `ST_T1 && !data_oe_n)
                addr <= data_out;
            // Outside T3 the bus shows a pattern that changes every cycle
            data_in <= (state_out == `ST_T3) ? mem[addr] : ~data_in;
        end
    end
endmodule // mem_model

/* test/test_cpu_state_sequencer.sv */
/* Self-checking bench: register moves, halt, interrupt, restart.
   Assumes mem_model supplies phases, ready and instruction bytes. */
`timescale 1ns/1ps
`include "cpu_state_sequencer_defs.vh"
module test_cpu_state_sequencer;
    reg         clk_sys, rst, intr_req, flag_s, flag_z, flag_p, flag_c;
    reg         cond_true;
    reg  [7:0]  reg_src, reg_l, reg_h, reg_acc, last_do;
    reg  [13:0] stack_top, pc_x;
    wire        phi1, phi2, ready, data_oe_n, sync, stopped, int_ack;
    wire [7:0]  data_in, data_out, temp_b;
    wire [4:0]  state_out;
    wire [13:0] pc;
    integer     err_total, n_checks, i, n;

    cpu_state_sequencer DUT (.clk_sys(clk_sys), .rst(rst), .phi1(phi1),
        .phi2(phi2), .ready(ready), .intr_req(intr_req), .data_in(data_in),
        .reg_src(reg_src), .reg_l(reg_l), .reg_h(reg_h), .reg_acc(reg_acc),
        .flag_s(flag_s), .flag_z(flag_z), .flag_p(flag_p), .flag_c(flag_c),
        .cond_true(cond_true), .stack_top(stack_top), .data_out(data_out),
        .data_oe_n(data_oe_n), .sync(sync), .state_out(state_out),
        .stopped(stopped), .waiting(), .int_ack(int_ack), .refresh(),
        .precharge(), .transfer(), .instruction_holding_reg(), .temp_a(),
        .temp_b(temp_b), .pc(pc), .push_stack(), .pop_stack(),
        .alu_op_go(), .inc_op_go(), .dec_op_go(), .rot_op_go(),
        .load_dest());
    mem_model mm (.clk_sys(clk_sys), .rst(rst), .state_out(state_out),
        .data_out(data_out), .data_oe_n(data_oe_n), .phi1(phi1),
        .phi2(phi2), .ready(ready), .data_in(data_in));

    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t seen %h exp %h",
                         $time, seen, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Bounded wait: 0 stopped, 1 acknowledge, 2 back in T1
    task wait_hi(input integer sel);
        integer t;
        begin
            for (t = 0; t < 2000 && (sel == 0 ? stopped : sel == 1 ?
                 int_ack : state_out == `ST_T1) !== 1'b1; t = t + 1) begin
                @(posedge clk_sys);
                #1;
            end
            if (t == 2000) begin
                err_total = err_total + 1;
                end_sim;
            end
        end
    endtask
    // Count state changes from T1 back to T1; note pc on entering T3
    task run_instr;
        reg [4:0] prev;
        integer t;
        begin
            #1;
            n = 0;
            prev = state_out;
            for (t = 0; t < 4000 && !(n > 0 && prev === `ST_T1); t = t + 1)
            begin
                last_do = data_out;
                @(posedge clk_sys);
                #1;
                if (state_out !== prev) begin
                    n = n + 1;
                    if (state_out === `ST_T3) begin
                        pc_x = pc;
                        check(last_do[7:6], `CYC_FETCH);
                    end
                end
                prev = state_out;
            end
            if (t == 4000) begin
                err_total = err_total + 1;
                end_sim;
            end
        end
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        err_total = 0;
        n_checks = 0;
        {rst, intr_req, reg_src, reg_l, reg_h, reg_acc} = {2'b10, 32'h0};
        {stack_top, flag_s, flag_z, flag_p, flag_c, cond_true} = 19'h0;
        n = $urandom(38);
        // Random register moves, never a memory operand
        for (i = 0; i < 256; i = i + 1)
            mm.mem[i] = {2'b11, 3'($urandom % 7), 3'($urandom % 7)};
        mm.mem[8'h20] = 8'h00; // Halt after 32 moves
        mm.mem[8'h21] = 8'h2d; // Restart, vector field 5
        repeat (7) @(posedge clk_sys);
        #1;
        check(state_out, `ST_T1);
        check({pc, data_oe_n, sync}, 16'h0002);
        @(posedge clk_sys) rst <= 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            @(posedge clk_sys);
            {reg_src, reg_l, reg_h, reg_acc} <= $urandom;
            {stack_top, flag_s, flag_z, flag_p, flag_c, cond_true} <=
                19'($urandom);
            run_instr;
            check(n, 5);
            check(pc_x, i + 1);
            check(temp_b, reg_src);
        end
        wait_hi(0);
        check(pc, 14'h21);
        repeat (40) @(posedge clk_sys);
        #1;
        check({stopped, state_out}, {1'b1, `ST_T3});
        @(posedge clk_sys) intr_req <= 1'b1;
        wait_hi(1);
        @(posedge clk_sys) intr_req <= 1'b0;
        wait_hi(2);
        run_instr;
        check(pc_x, 14'h21);
        check(n, 5);
        run_instr;
        check(pc_x, 14'h29);
        end_sim;
    end
endmodule // test_cpu_state_sequencer
